// ---- hw/itg_cmd.sv ----
// idle, idle immediate and geometry command interpreter with standby timer
//
// Summary of operation
// - idle enters idle, loads and starts timer
// - spin up only when spindle stopped
// - timeout zero disables automatic standby
// - codes 1-240 times five, 241-251 half-hours
// - 252, 253, 255 fixed; 254 aborts
// - timer expiry sends drive to standby
// - host access reloads full interval
// - idle immediate keeps stored timeout
// - geometry command stores sectors and heads
// - geometry reported in identify words
// - geometry lost on soft reset if reverting
// - zero sectors means zero, not 256
// - head field limited to 0-15
`timescale 1ns/1ps
module itg_cmd
	import itg_pkg::*;
#(
	parameter int TICK_CNT = TICK_CYCLES
)
(
	input  wire logic       REF_CLK,
	input  wire logic       RST_N,
	input  wire logic       CMD_VALID,
	input  wire itg_cmd_t   CMD,
	output logic            CMD_READY,
	input  wire logic       HOST_ACCESS,
	input  wire logic       SPINDLE_TURNING,
	input  wire logic       SPINUP_DONE,
	input  wire logic       SOFT_RESET,
	input  wire logic       REVERT_ON_RESET,
	output logic            SPINUP_REQ,
	output logic            STANDBY_REQ,
	output itg_pmode_t      PWR_MODE,
	output logic            DONE,
	output itg_stat_t       STATUS,
	output logic [7:0]      ERROR,
	output logic [15:0]     ID_HEADS,
	output logic [15:0]     ID_SECTORS
);
	typedef enum logic {ST_READY, ST_SPIN} itg_state_t;

	itg_state_t        state_r;
	itg_pmode_t        pmode_r;
	logic              accept;
	logic              is_idle;
	logic              is_imm;
	logic              is_geom;
	logic              tmo_abort;
	logic              cmd_abort;
	logic              go_idle;
	logic [15:0]       tmo_secs;
	logic [15:0]       period_r;
	logic [15:0]       sec_r;
	logic [31:0]       presc_r;
	logic              armed;
	logic              tick;
	logic              expire;
	logic              spinup_r;
	logic              standby_r;
	logic              done_r;
	logic              busy_r;
	logic              abort_r;
	logic [7:0]        spt_r;
	logic [HEAD_W-1:0] head_r;

	itg_tmo_dec u_dec (
		.code  (CMD.sect_cnt),
		.secs  (tmo_secs),
		.abort (tmo_abort)
	);

	assign CMD_READY = (state_r == ST_READY);
	assign accept = CMD_VALID && CMD_READY;
	assign is_idle = (CMD.opcode == OP_IDLE_A) || (CMD.opcode == OP_IDLE_B);
	assign is_imm = (CMD.opcode == OP_IDLE_IMM_A) || (CMD.opcode == OP_IDLE_IMM_B);
	assign is_geom = (CMD.opcode == OP_INIT_GEOM);
	// unknown opcodes are refused the same way as the reserved timeout code
	assign cmd_abort = (is_idle && tmo_abort) || !(is_idle || is_imm || is_geom);
	assign go_idle = accept && !cmd_abort && (is_idle || is_imm);

	// command sequencing: spin-up is the only wait
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			state_r <= ST_READY;
		end else begin
			unique case (state_r)
				ST_READY: begin
					if (go_idle && !SPINDLE_TURNING) begin
						state_r <= ST_SPIN;
					end
				end
				ST_SPIN: begin
					if (SPINUP_DONE) begin
						state_r <= ST_READY;
					end
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			spinup_r <= 1'b0;
		end else begin
			spinup_r <= go_idle && !SPINDLE_TURNING;
		end
	end

	// power mode
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			pmode_r <= PM_IDLE;
		end else if (go_idle) begin
			pmode_r <= PM_IDLE;
		end else if (expire) begin
			pmode_r <= PM_STANDBY;
		end
	end

	// stored timeout: only the idle command touches it
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			period_r <= 16'h0000;
		end else if (go_idle && is_idle) begin
			period_r <= tmo_secs;
		end
	end

	// one-second prescaler; long enough to need a parameter for simulation
	assign armed = (period_r != 16'h0000) && (pmode_r == PM_IDLE);
	assign tick = armed && (presc_r == 32'(TICK_CNT - 1));
	assign expire = tick && (sec_r == 16'h0001) && !HOST_ACCESS && !accept;

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			presc_r <= 32'h0000_0000;
		end else if (!armed || HOST_ACCESS || accept || tick) begin
			presc_r <= 32'h0000_0000;
		end else begin
			presc_r <= presc_r + 32'h0000_0001;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			sec_r <= 16'h0000;
		end else if (go_idle && is_idle) begin
			sec_r <= tmo_secs;
		end else if (HOST_ACCESS || accept) begin
			sec_r <= period_r;
		end else if (tick) begin
			sec_r <= sec_r - 16'h0001;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			standby_r <= 1'b0;
		end else begin
			standby_r <= expire;
		end
	end

	// geometry; a zero sector count is kept as zero
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			spt_r <= SPT_RST;
			head_r <= HEAD_RST;
		end else if (accept && is_geom) begin
			spt_r <= CMD.sect_cnt;
			head_r <= CMD.dev_head[HEAD_W-1:0];
		end else if (SOFT_RESET && REVERT_ON_RESET) begin
			spt_r <= SPT_RST;
			head_r <= HEAD_RST;
		end
	end

	// identify words carry heads as a count, hence the plus one
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			ID_HEADS <= 16'h0000;
			ID_SECTORS <= 16'h0000;
		end else begin
			ID_HEADS <= {12'h000, head_r} + 16'h0001;
			ID_SECTORS <= {8'h00, spt_r};
		end
	end

	// completion
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			done_r <= 1'b0;
			busy_r <= 1'b0;
			abort_r <= 1'b0;
		end else begin
			done_r <= (accept && !(go_idle && !SPINDLE_TURNING))
				|| (state_r == ST_SPIN && SPINUP_DONE);
			busy_r <= (go_idle && !SPINDLE_TURNING) || (state_r == ST_SPIN && !SPINUP_DONE);
			if (accept) begin
				abort_r <= cmd_abort;
			end
		end
	end

	assign SPINUP_REQ = spinup_r;
	assign STANDBY_REQ = standby_r;
	assign PWR_MODE = pmode_r;
	assign DONE = done_r;

	always_comb begin
		STATUS = '0;
		STATUS.bsy = busy_r;
		STATUS.rdy = 1'b1;
		STATUS.df = 1'b0;
		STATUS.dsc = 1'b1;
		STATUS.err = abort_r;
		ERROR = 8'h00;
		ERROR[ERR_ABT_BIT] = abort_r;
	end

	AST_ABORT_254: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		accept && is_idle && CMD.sect_cnt == TMO_ABORT
		|=> DONE && STATUS.err && ERROR[ERR_ABT_BIT] && $stable(period_r))
		else $error("code 254 not aborted");

	AST_TMO_ZERO: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		period_r == 16'h0000 |=> !STANDBY_REQ)
		else $error("standby with timer disabled");

	AST_IDLE_LOAD: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		go_idle && is_idle |=> PWR_MODE == PM_IDLE && sec_r == $past(tmo_secs)
		&& period_r == $past(tmo_secs))
		else $error("idle did not load timer");

	AST_SPINUP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		go_idle |=> SPINUP_REQ == !$past(SPINDLE_TURNING) && STATUS.bsy == SPINUP_REQ)
		else $error("spin-up decision wrong");

	AST_RELOAD: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		HOST_ACCESS && !accept |=> sec_r == period_r && presc_r == 32'h0000_0000)
		else $error("access did not reload timer");

	AST_IMM_KEEP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		accept && is_imm |=> $stable(period_r) && PWR_MODE == PM_IDLE)
		else $error("idle immediate changed timeout");

	AST_STANDBY: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		STANDBY_REQ |-> PWR_MODE == PM_STANDBY && $past(armed) && $past(sec_r) == 16'h0001)
		else $error("standby without expiry");

	AST_DECODE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		accept && is_idle && CMD.sect_cnt == 8'hf1 |-> tmo_secs == TMO_LONG_MUL)
		else $error("timeout decode wrong");

	AST_GEOM: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		accept && is_geom |=> ##1 ID_SECTORS == {8'h00, $past(CMD.sect_cnt, 2)}
		&& ID_HEADS == {12'h000, $past(CMD.dev_head[3:0], 2)} + 16'h0001)
		else $error("geometry not reported");

	AST_REVERT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		SOFT_RESET && !REVERT_ON_RESET && !(accept && is_geom) |=> $stable(spt_r))
		else $error("geometry lost without revert");

	AST_DONE_CLEAN: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		DONE |-> !STATUS.bsy && !STATUS.df && STATUS.err == ERROR[ERR_ABT_BIT])
		else $error("completion status wrong");

	// upper end points of both multiplied ranges, worked out by hand
	AST_DECODE_MAX: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		accept && is_idle && CMD.sect_cnt == TMO_SHORT_MAX |-> tmo_secs == 16'h04b0)
		else $error("short timeout decode wrong");

	AST_DECODE_TOP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		accept && is_idle && CMD.sect_cnt == TMO_LONG_MAX |-> tmo_secs == 16'h4d58)
		else $error("long timeout decode wrong");

	AST_DECODE_8H: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		accept && is_idle && CMD.sect_cnt == TMO_8H |-> tmo_secs == TMO_8H_SEC && !cmd_abort)
		else $error("eight hour code decode wrong");

	AST_ACCESS_WINS: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		HOST_ACCESS |=> !STANDBY_REQ)
		else $error("standby despite host access");

	AST_NO_SPINUP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		go_idle && SPINDLE_TURNING |=> DONE && CMD_READY && !SPINUP_REQ)
		else $error("spin-up on a turning spindle");

	AST_REVERT_CLR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		SOFT_RESET && REVERT_ON_RESET && !(accept && is_geom)
		|=> spt_r == SPT_RST && head_r == HEAD_RST)
		else $error("geometry kept through reverting reset");

	AST_ZERO_SPT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		accept && is_geom && CMD.sect_cnt == 8'h00 |=> ##1 ID_SECTORS == 16'h0000)
		else $error("zero sectors not kept as zero");

	// the drive select bit shares the byte and must not leak into the count
	AST_HEAD_FIELD: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		accept && is_geom |=> head_r == $past(CMD.dev_head[3:0]))
		else $error("head field taken wrongly");

	AST_BUSY_READY: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		STATUS.bsy == !CMD_READY)
		else $error("busy and ready disagree");
endmodule

// ---- hw/itg_tmo_dec.sv ----
// standby timeout code to seconds decoder
`timescale 1ns/1ps
module itg_tmo_dec
	import itg_pkg::*;
(
	input  wire logic [7:0]  code,
	output logic      [15:0] secs,
	output logic             abort
);
	logic [15:0] code_w;

	always_comb begin
		code_w = {8'h00, code};
		abort = 1'b0;
		secs = 16'h0000;
		if (code == TMO_OFF) begin
			secs = 16'h0000;
		end else if (code <= TMO_SHORT_MAX) begin
			secs = 16'(code_w * TMO_SHORT_MUL);
		end else if (code <= TMO_LONG_MAX) begin
			secs = 16'((code_w - {8'h00, TMO_SHORT_MAX}) * TMO_LONG_MUL);
		end else if (code == TMO_21M) begin
			secs = TMO_21M_SEC;
		end else if (code == TMO_8H) begin
			secs = TMO_8H_SEC;
		end else if (code == TMO_ABORT) begin
			abort = 1'b1;
		end else begin
			secs = TMO_21M15S_SEC;
		end
	end
endmodule

// ---- pkg/itg_pkg.sv ----
// shared constants and types for the idle timer and geometry command block
package itg_pkg;
	localparam logic [7:0]  OP_IDLE_A      = 8'he3;
	localparam logic [7:0]  OP_IDLE_B      = 8'h97;
	localparam logic [7:0]  OP_IDLE_IMM_A  = 8'he1;
	localparam logic [7:0]  OP_IDLE_IMM_B  = 8'h95;
	localparam logic [7:0]  OP_INIT_GEOM   = 8'h91;
	localparam logic [7:0]  TMO_OFF        = 8'h00;
	localparam logic [7:0]  TMO_SHORT_MAX  = 8'hf0;
	localparam logic [7:0]  TMO_LONG_MAX   = 8'hfb;
	localparam logic [7:0]  TMO_21M        = 8'hfc;
	localparam logic [7:0]  TMO_8H         = 8'hfd;
	localparam logic [7:0]  TMO_ABORT      = 8'hfe;
	localparam logic [7:0]  TMO_21M15S     = 8'hff;
	localparam logic [15:0] TMO_SHORT_MUL  = 16'h0005;
	localparam logic [15:0] TMO_LONG_MUL   = 16'h0708;
	localparam logic [15:0] TMO_21M_SEC    = 16'h04ec;
	localparam logic [15:0] TMO_8H_SEC     = 16'h7080;
	localparam logic [15:0] TMO_21M15S_SEC = 16'h04fb;
	localparam int          TICK_SEC       = 1;
	localparam int          CLK_MHZ        = 100;
	localparam int          TICK_CYCLES    = TICK_SEC * CLK_MHZ * 1000000;
	localparam int          HEAD_W         = 4;
	localparam logic [7:0]  SPT_RST        = 8'h00;
	localparam logic [3:0]  HEAD_RST       = 4'h0;
	localparam int          ERR_ABT_BIT    = 2;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] sect_cnt;
		logic [7:0] dev_head;
	} itg_cmd_t;

	typedef struct packed {
		logic bsy;
		logic rdy;
		logic df;
		logic dsc;
		logic drq;
		logic cor;
		logic idx;
		logic err;
	} itg_stat_t;

	typedef enum logic {PM_IDLE, PM_STANDBY} itg_pmode_t;
endpackage

// ---- tb/itg_host.sv ----
// host model that issues task-file commands and host accesses
`timescale 1ns/1ps
module itg_host
	import itg_pkg::*;
(
	input  wire logic REF_CLK,
	input  wire logic CMD_READY,
	input  wire logic DONE,
	output logic      CMD_VALID,
	output itg_cmd_t  CMD,
	output logic      HOST_ACCESS
);
	initial begin
		CMD_VALID = 1'b0;
		CMD = '0;
		HOST_ACCESS = 1'b0;
	end
	// fields are inverted after release so stale values are never trusted
	task automatic issue(input logic [7:0] op, sc, dh, output int lat);
		lat = 0;
		@(posedge REF_CLK);
		CMD_VALID <= 1'b1;
		CMD <= {op, sc, dh};
		// ready is read at the edge, before the design updates it
		do @(posedge REF_CLK); while (CMD_READY !== 1'b1);
		CMD_VALID <= 1'b0;
		CMD <= ~{op, sc, dh};
		#1;
		while (DONE !== 1'b1 && lat < 500) begin
			@(posedge REF_CLK);
			#1;
			lat++;
		end
	endtask
	task automatic access();
		@(posedge REF_CLK);
		HOST_ACCESS <= 1'b1;
		@(posedge REF_CLK);
		HOST_ACCESS <= 1'b0;
	endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the idle timer and geometry commands
`timescale 1ns/1ps
module tb;
	import itg_pkg::*;
	// short second keeps the long timeout codes affordable
	localparam int TK = 10;
	logic        clk, rst_n, cmd_valid, cmd_ready, host_access, spin_on, spin_done;
	logic        soft_rst, revert, spin_req, sb_req, done;
	itg_cmd_t    cmd;
	itg_stat_t   status;
	itg_pmode_t  pwr_mode;
	logic [7:0]  error, sc, h;
	logic [15:0] id_heads, id_sectors;
	logic [7:0]  codes [5] = '{8'h01, 8'hf0, 8'hf1, 8'hfc, 8'hff};
	int          error_cnt, samples_checked, seed, lat, n, spins;

	itg_cmd #(.TICK_CNT(TK)) u_itg_cmd (.REF_CLK(clk), .RST_N(rst_n), .CMD_VALID(cmd_valid),
		.CMD(cmd), .CMD_READY(cmd_ready), .HOST_ACCESS(host_access), .SPINDLE_TURNING(spin_on),
		.SPINUP_DONE(spin_done), .SOFT_RESET(soft_rst), .REVERT_ON_RESET(revert),
		.SPINUP_REQ(spin_req), .STANDBY_REQ(sb_req), .PWR_MODE(pwr_mode), .DONE(done),
		.STATUS(status), .ERROR(error), .ID_HEADS(id_heads), .ID_SECTORS(id_sectors));
	itg_host u_itg_host (.REF_CLK(clk), .CMD_READY(cmd_ready), .DONE(done),
		.CMD_VALID(cmd_valid), .CMD(cmd), .HOST_ACCESS(host_access));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (spin_req === 1'b1) spins++;

	task automatic chk(input string nm, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic int tmo_s(input logic [7:0] c);
		if (c <= 8'hf0) return int'(c) * 5;
		if (c <= 8'hfb) return (int'(c) - 240) * 1800;
		return (c == 8'hfc) ? 1260 : (c == 8'hfd) ? 28800 : 1275;
	endfunction
	// count cycles to the standby pulse, bounded
	task automatic wait_sb(input int lim);
		n = 0;
		while (sb_req !== 1'b1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic chk_sb(input int e);
		chk("standby_at", 16'h1, 16'(n >= e - 3 && n <= e + 3));
		chk("pwr_mode", 16'(PM_STANDBY), 16'(pwr_mode));
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge clk);
		error_cnt++;
		final_report();
	end

	initial begin
		seed = 42;
		{rst_n, spin_on, spin_done, soft_rst, revert} = 5'b01000;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		foreach (codes[i]) begin
			u_itg_host.issue((i % 2) ? OP_IDLE_B : OP_IDLE_A, codes[i], 8'ha0, lat);
			chk("status", 16'h0050, 16'(status));
			chk("done_lat", 16'h0, 16'(lat));
			wait_sb(20000);
			chk_sb(tmo_s(codes[i]) * TK);
		end
		u_itg_host.issue(OP_IDLE_A, 8'h02, 8'ha0, lat);
		chk("pwr_mode", 16'(PM_IDLE), 16'(pwr_mode));
		repeat (60) @(posedge clk);
		u_itg_host.access();
		wait_sb(400);
		chk_sb(10 * TK);
		u_itg_host.issue(OP_IDLE_A, 8'h01, 8'ha0, lat);
		repeat (20) @(posedge clk);
		u_itg_host.issue(OP_IDLE_IMM_B, 8'h00, 8'ha0, lat);
		wait_sb(400);
		chk_sb(5 * TK);
		u_itg_host.issue(OP_IDLE_B, TMO_OFF, 8'ha0, lat);
		wait_sb(400);
		chk("no_standby", 16'd400, 16'(n));
		// eight hours cannot run out here; only the decode and the idle mode are seen
		u_itg_host.issue(OP_IDLE_B, TMO_8H, 8'ha0, lat);
		wait_sb(300);
		chk("no_standby_8h", 16'd300, 16'(n));
		chk("pwr_mode", 16'(PM_IDLE), 16'(pwr_mode));
		u_itg_host.issue(OP_IDLE_A, TMO_ABORT, 8'ha0, lat);
		chk("error", 16'h0004, 16'(error));
		chk("status", 16'h0051, 16'(status));
		@(posedge clk);
		spin_on <= 1'b0;
		spins = 0;
		fork
			u_itg_host.issue(OP_IDLE_IMM_A, 8'h00, 8'ha0, lat);
			begin
				repeat (4) @(posedge clk);
				#1;
				chk("busy", 16'h1, 16'({status.bsy, cmd_ready} == 2'b10));
				@(posedge clk);
				spin_done <= 1'b1;
				@(posedge clk);
				spin_done <= 1'b0;
			end
		join
		chk("spinups", 16'h1, 16'(spins));
		chk("done_lat", 16'd4, 16'(lat));
		chk("status", 16'h0050, 16'(status));
		@(posedge clk);
		spin_on <= 1'b1;
		u_itg_host.issue(OP_IDLE_IMM_A, 8'h00, 8'ha0, lat);
		chk("spinups", 16'h1, 16'(spins));
		for (int i = 0; i < 8; i++) begin
			// host keeps the head field in range; the sector count is random, zero on the first pass
			sc = (i == 0) ? 8'h00 : 8'($random(seed));
			h = 8'($random(seed)) & 8'h0f;
			u_itg_host.issue(OP_INIT_GEOM, sc, 8'ha0 | h, lat);
			@(posedge clk);
			#1;
			chk("id_sectors", {8'h00, sc}, id_sectors);
			chk("id_heads", 16'(h) + 16'h1, id_heads);
		end
		for (int r = 0; r < 2; r++) begin
			@(posedge clk);
			{soft_rst, revert} <= {1'b1, 1'(r)};
			@(posedge clk);
			soft_rst <= 1'b0;
			@(posedge clk);
			#1;
			chk("id_sectors", (r == 1) ? 16'h0 : {8'h00, sc}, id_sectors);
			chk("id_heads", (r == 1) ? 16'h1 : 16'(h) + 16'h1, id_heads);
		end
		final_report();
	end
endmodule
